// File: include/pspc_regs.svh
`ifndef PSPC_REGS_SVH
`define PSPC_REGS_SVH

// register word indices on the plain register port
`define PSPC_REG_CTRL      4'h0
`define PSPC_REG_KNOB      4'h1
`define PSPC_REG_ANALOG    4'h2
`define PSPC_REG_FAST      4'h3
`define PSPC_REG_SLOW      4'h4
`define PSPC_REG_STATUS    4'h5
`define PSPC_REG_STROKES   4'h6
`define PSPC_REG_PULSES    4'h7

// field positions
`define PSPC_CTRL_ANALOG_BIT  0
`define PSPC_STAT_MODE_BIT    0
`define PSPC_STAT_RUN_BIT     1
`define PSPC_STAT_LOW_BIT     2
`define PSPC_STAT_REMON_BIT   3
`define PSPC_STAT_STROKE_BIT  4

// pin vector positions inside the synchroniser
`define PSPC_PIN_BTN   0
`define PSPC_PIN_REM   1
`define PSPC_PIN_PLS   2
`define PSPC_PIN_LOW   3
`define PSPC_PIN_NVM   4
`define PSPC_PIN_NVV   5
`define PSPC_PIN_COUNT 6

// reset values
`define PSPC_KNOB_RST     7'h32
`define PSPC_FAST_RST     16'h4E20
`define PSPC_SLOW_RST     16'h0FA0

// timing, clock and millisecond figures
`define PSPC_CLK_PERIOD_NS 100
`define PSPC_MS_NS         1000000
`define PSPC_MS_CYCLES     (`PSPC_MS_NS / `PSPC_CLK_PERIOD_NS)
`define PSPC_PULSE_MIN_MS  8'h19
`define PSPC_PULSE_GAP_MS  8'h32
`define PSPC_CAP_SPM       8'hF0
`define PSPC_CAP_GAP_MS    8'hFA
`define PSPC_STROKE_MS     8'h64
`define PSPC_MS_PER_MIN    32'h0000EA60
`define PSPC_KNOB_THR      32'h005B8D80
`define PSPC_KNOB_MIN_INC  32'h00000064

`endif

// File: include/pspc_pkg.sv
`include "pspc_regs.svh"

package pspc_pkg;

  // operating mode, kept across power loss
  typedef enum logic {
    PSPC_LOCAL  = 1'b0,
    PSPC_REMOTE = 1'b1
  } pspc_mode_t;

  // pulse contact qualifier
  typedef enum logic [1:0] {
    PSPC_PQ_OPEN   = 2'b00,
    PSPC_PQ_CLOSED = 2'b01
  } pspc_pq_t;

  // stroke generator
  typedef enum logic [1:0] {
    PSPC_SG_REST   = 2'b00,
    PSPC_SG_STROKE = 2'b01
  } pspc_sg_t;

endpackage

// File: include/pspc_rate_if.sv
// joins the controller, the millisecond base and the stroke generator
interface pspc_rate_if;
  logic        ms_tick;
  logic        run;
  logic        credit_mode;
  logic        credit_req;
  logic [31:0] inc;
  logic [31:0] thr;
  logic        stroke_on;

  modport ctl  (input ms_tick, input stroke_on, output run, output credit_mode, output credit_req,
                output inc, output thr);
  modport gen  (input ms_tick, input run, input credit_mode, input credit_req, input inc, input thr,
                output stroke_on);
  modport base (output ms_tick);
endinterface

// File: logic/pspc_msbase.sv
// one-cycle tick every millisecond
module pspc_msbase
  import pspc_pkg::*;
#(
  parameter int MS_CYCLES = `PSPC_MS_CYCLES
) (
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // tick out
  pspc_rate_if.base   rif
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } pspc_msb_t;

  pspc_msb_t st_ff;
  pspc_msb_t nxt_st;

  // divider wraps at one millisecond
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == 16'(MS_CYCLES - 1)) begin
      nxt_st.cnt  = 16'h0000;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rif.ms_tick = st_ff.tick;

endmodule

// File: logic/pspc_strokegen.sv
// stroke timing: phase accumulator or pulse credits
module pspc_strokegen
  import pspc_pkg::*;
(
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // rate control
  pspc_rate_if.gen    rif
);

  typedef struct packed {
    pspc_sg_t    sg;
    logic [31:0] acc;
    logic [7:0]  gap_ms;
    logic [7:0]  on_ms;
    logic        pend;
  } pspc_sgs_t;

  pspc_sgs_t   st_ff;
  pspc_sgs_t   nxt_st;
  logic [32:0] sum;
  logic        fire;

  // accumulate rate per millisecond, fire when a whole stroke is due
  always_comb begin
    nxt_st = st_ff;
    sum    = {1'b0, st_ff.acc} + {1'b0, rif.inc};
    fire   = 1'b0;
    if (rif.credit_req) begin
      nxt_st.pend = 1'b1;
    end
    if (rif.ms_tick) begin
      if (st_ff.gap_ms != 8'hFF) begin
        nxt_st.gap_ms = st_ff.gap_ms + 8'h01;
      end
      case (st_ff.sg)
        PSPC_SG_STROKE: begin
          nxt_st.on_ms = st_ff.on_ms + 8'h01;
          if (st_ff.on_ms + 8'h01 >= `PSPC_STROKE_MS) begin
            nxt_st.sg = PSPC_SG_REST;
          end
        end
        PSPC_SG_REST: begin
          // spacing floor caps any source at the top stroke rate
          if (rif.run && st_ff.gap_ms >= `PSPC_CAP_GAP_MS) begin
            if (rif.credit_mode) begin
              fire = st_ff.pend;
            end else if (rif.thr != 32'h00000000) begin
              fire = sum >= {1'b0, rif.thr};
            end
          end
        end
        default: nxt_st.sg = PSPC_SG_REST;
      endcase
      if (!rif.credit_mode && rif.run) begin
        nxt_st.acc = fire ? 32'(sum - {1'b0, rif.thr}) : sum[31:0];
      end
      if (fire) begin
        nxt_st.sg     = PSPC_SG_STROKE;
        nxt_st.on_ms  = 8'h00;
        nxt_st.gap_ms = 8'h00;
        // a credit arriving now is kept for the next stroke
        nxt_st.pend   = rif.credit_req;
      end
    end
    if (!rif.run) begin
      nxt_st.acc  = 32'h00000000;
      nxt_st.pend = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '{sg: PSPC_SG_REST, acc: 32'h00000000, gap_ms: 8'hFF, on_ms: 8'h00, pend: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rif.stroke_on = (st_ff.sg == PSPC_SG_STROKE);

endmodule

// File: logic/pspc_top.sv
// Function
// - each debounced mode button press toggles local and remote mode.
// - with no valid stored mode the pump starts in local mode.
// - local mode ignores the remote on/off contact.
// - remote mode follows the synchronised remote on/off contact every cycle.
// - mode is loaded from and written back to nonvolatile storage.
// - open remote contact stops pumping; pulses or current act only when closed.
// - green indicator in local mode, yellow in remote mode.
// - local mode stroke rate follows the speed knob value.
// - reject pulses closed under 25 ms or starting under 50 ms apart.
// - accepted pulses faster than 240 per minute stroke at 240 per minute.
// - accepted pulses slower than 240 per minute give one stroke each.
// - a pulse starts on contact closure and ends on opening.
// - analog mode maps 4 mA to zero and 20 mA to full speed.
// - at or above fast level full speed, below slow level stopped.
// - indicator lit between strokes, dark during a stroke.
// - closed low-level input stops the pump and lights red.
//
// Design decisions made here: strobed register access and the register addresses.
module pspc_top
  import pspc_pkg::*;
#(
  parameter int MS_CYCLES = `PSPC_MS_CYCLES
) (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  // register port
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [15:0] REG_RDATA,
  // contacts, high when closed
  input  wire logic        MODE_BUTTON,
  input  wire logic        REMOTE_ON,
  input  wire logic        PULSE_IN,
  input  wire logic        LOW_LEVEL,
  // nonvolatile mode store
  input  wire logic        NV_MODE,
  input  wire logic        NV_VALID,
  output logic             NV_MODE_D,
  output logic             NV_WR,
  // drive and indicators
  output logic             STROKE,
  output logic             LED_GREEN,
  output logic             LED_YELLOW,
  output logic             LED_RED
);

  typedef struct packed {
    logic [`PSPC_PIN_COUNT-1:0] sync1;
    logic [`PSPC_PIN_COUNT-1:0] sync2;
    logic [1:0]                 init_cnt;
    pspc_mode_t                 mode;
    logic                       btn_a;
    logic                       btn_b;
    pspc_pq_t                   pq;
    logic [7:0]                 hi_ms;
    logic [7:0]                 gap_ms;
    logic                       gap_ok;
    logic                       credit;
    logic                       analog;
    logic [6:0]                 knob;
    logic [15:0]                ma_in;
    logic [15:0]                fast;
    logic [15:0]                slow;
    logic [15:0]                rdata;
    logic [15:0]                strokes;
    logic [7:0]                 acc_cnt;
    logic [7:0]                 rej_cnt;
    logic                       stroke_d;
    logic                       nv_d;
    logic                       nv_wr;
    logic                       stroke;
    logic                       led_g;
    logic                       led_y;
    logic                       led_r;
  } pspc_top_t;

  pspc_top_t   st_ff;
  pspc_top_t   nxt_st;
  pspc_rate_if rif ();

  logic        btn_now;
  logic        rem_on;
  logic        pls_on;
  logic        low_on;
  logic        ready;
  logic        running;
  logic        remote;
  logic [15:0] ma_cl;
  logic [15:0] span;
  logic [31:0] inc_v;
  logic [31:0] thr_v;

  // address hit for a given register index
  function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] idx);
    reg_hit = (addr == idx);
  endfunction

  // millisecond base and stroke generator
  pspc_msbase #(
    .MS_CYCLES (MS_CYCLES)
  ) u_msbase (
    .clk (SYS_CLK),
    .rst (RESET),
    .rif (rif.base)
  );

  pspc_strokegen u_strokegen (
    .clk (SYS_CLK),
    .rst (RESET),
    .rif (rif.gen)
  );

  // synchronised contact levels; only the second stage is read
  assign btn_now = st_ff.sync2[`PSPC_PIN_BTN];
  assign rem_on  = st_ff.sync2[`PSPC_PIN_REM];
  assign pls_on  = st_ff.sync2[`PSPC_PIN_PLS];
  assign low_on  = st_ff.sync2[`PSPC_PIN_LOW];
  assign ready   = (st_ff.init_cnt == 2'h3);
  assign remote  = (st_ff.mode == PSPC_REMOTE);

  // run gate: low level stops every mode, remote contact only counts in remote
  assign running = ready && !low_on
                   && (!remote || rem_on);

  // analog mapping, input clamped to the fast level
  assign ma_cl = (st_ff.ma_in >= st_ff.fast) ? st_ff.fast : st_ff.ma_in;
  assign span  = st_ff.fast - st_ff.slow;

  // rate source per mode
  always_comb begin
    inc_v = 32'h00000000;
    thr_v = 32'h00000000;
    if (!remote) begin
      // knob percent times top rate, with a floor of one stroke per minute
      inc_v = {17'h0, st_ff.knob, 8'h00} - {21'h0, st_ff.knob, 4'h0};
      if (inc_v < `PSPC_KNOB_MIN_INC) begin
        inc_v = `PSPC_KNOB_MIN_INC;
      end
      thr_v = `PSPC_KNOB_THR;
    end else if (st_ff.analog) begin
      // reverse action is not supported: fast not above slow keeps the pump stopped
      if (st_ff.fast > st_ff.slow && st_ff.ma_in >= st_ff.slow) begin
        inc_v = {16'h0000, ma_cl - st_ff.slow} * {24'h000000, `PSPC_CAP_SPM};
        thr_v = 32'({16'h0000, span} * `PSPC_MS_PER_MIN);
      end
    end
  end

  assign rif.run         = running;
  assign rif.credit_mode = remote && !st_ff.analog;
  assign rif.credit_req  = st_ff.credit;
  assign rif.inc         = inc_v;
  assign rif.thr         = thr_v;

  // next state of the controller
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.sync1    = {NV_VALID, NV_MODE, LOW_LEVEL, PULSE_IN, REMOTE_ON, MODE_BUTTON};
    nxt_st.sync2    = st_ff.sync1;
    nxt_st.credit   = 1'b0;
    nxt_st.nv_wr    = 1'b0;
    nxt_st.rdata    = 16'h0000;
    nxt_st.stroke_d = rif.stroke_on;

    // stored mode is taken once the synchroniser holds real pin levels
    if (!ready) begin
      nxt_st.init_cnt = st_ff.init_cnt + 2'h1;
      if (st_ff.init_cnt == 2'h2) begin
        nxt_st.mode = st_ff.sync2[`PSPC_PIN_NVV]
                      ? pspc_mode_t'(st_ff.sync2[`PSPC_PIN_NVM]) : PSPC_LOCAL;
        nxt_st.nv_d = st_ff.sync2[`PSPC_PIN_NVV] ? st_ff.sync2[`PSPC_PIN_NVM] : 1'b0;
      end
    end

    // button debounce: released, then pressed on two millisecond samples
    if (rif.ms_tick) begin
      nxt_st.btn_a = btn_now;
      nxt_st.btn_b = st_ff.btn_a;
      if (ready && btn_now && st_ff.btn_a && !st_ff.btn_b) begin
        nxt_st.mode  = remote ? PSPC_LOCAL : PSPC_REMOTE;
        nxt_st.nv_d  = !remote;
        nxt_st.nv_wr = 1'b1;
      end
    end

    // millisecond gap since the previous pulse start, saturating
    if (rif.ms_tick && st_ff.gap_ms != 8'hFF) begin
      nxt_st.gap_ms = st_ff.gap_ms + 8'h01;
    end

    // pulse qualifier: closure starts, opening ends and judges the pulse
    case (st_ff.pq)
      PSPC_PQ_OPEN: begin
        if (pls_on) begin
          nxt_st.pq     = PSPC_PQ_CLOSED;
          nxt_st.hi_ms  = 8'h00;
          nxt_st.gap_ok = st_ff.gap_ms >= `PSPC_PULSE_GAP_MS;
          nxt_st.gap_ms = 8'h00;
        end
      end
      PSPC_PQ_CLOSED: begin
        if (rif.ms_tick && st_ff.hi_ms != 8'hFF) begin
          nxt_st.hi_ms = st_ff.hi_ms + 8'h01;
        end
        if (!pls_on) begin
          nxt_st.pq = PSPC_PQ_OPEN;
          // only a pulse seen while remote pulse pacing is live counts
          if (rif.credit_mode && running) begin
            if (st_ff.hi_ms >= `PSPC_PULSE_MIN_MS && st_ff.gap_ok) begin
              nxt_st.credit  = 1'b1;
              nxt_st.acc_cnt = st_ff.acc_cnt + 8'h01;
            end else begin
              nxt_st.rej_cnt = st_ff.rej_cnt + 8'h01;
            end
          end
        end
      end
      default: nxt_st.pq = PSPC_PQ_OPEN;
    endcase

    // count stroke starts for software
    if (rif.stroke_on && !st_ff.stroke_d) begin
      nxt_st.strokes = st_ff.strokes + 16'h0001;
    end

    // register writes
    if (REG_WR) begin
      if (reg_hit(REG_ADDR, `PSPC_REG_CTRL)) begin
        nxt_st.analog = REG_WDATA[`PSPC_CTRL_ANALOG_BIT];
      end
      if (reg_hit(REG_ADDR, `PSPC_REG_KNOB)) begin
        // knob beyond full scale is held at full scale
        nxt_st.knob = (REG_WDATA > 16'h0064) ? 7'h64 : REG_WDATA[6:0];
      end
      if (reg_hit(REG_ADDR, `PSPC_REG_ANALOG)) begin
        nxt_st.ma_in = REG_WDATA;
      end
      if (reg_hit(REG_ADDR, `PSPC_REG_FAST)) begin
        nxt_st.fast = REG_WDATA;
      end
      if (reg_hit(REG_ADDR, `PSPC_REG_SLOW)) begin
        nxt_st.slow = REG_WDATA;
      end
      if (reg_hit(REG_ADDR, `PSPC_REG_STROKES)) begin
        nxt_st.strokes = nxt_st.strokes - st_ff.strokes;  // a stroke start in the clearing cycle survives
      end
      if (reg_hit(REG_ADDR, `PSPC_REG_PULSES)) begin
        nxt_st.acc_cnt = nxt_st.acc_cnt - st_ff.acc_cnt;  // a pulse judged now is not lost
        nxt_st.rej_cnt = nxt_st.rej_cnt - st_ff.rej_cnt;
      end
    end

    // register reads, data valid in the following cycle only
    if (REG_RD) begin
      case (REG_ADDR)
        `PSPC_REG_CTRL:    nxt_st.rdata = {15'h0000, st_ff.analog};
        `PSPC_REG_KNOB:    nxt_st.rdata = {9'h000, st_ff.knob};
        `PSPC_REG_ANALOG:  nxt_st.rdata = st_ff.ma_in;
        `PSPC_REG_FAST:    nxt_st.rdata = st_ff.fast;
        `PSPC_REG_SLOW:    nxt_st.rdata = st_ff.slow;
        `PSPC_REG_STATUS:  nxt_st.rdata = {11'h000, rif.stroke_on, rem_on, low_on, running, remote};
        `PSPC_REG_STROKES: nxt_st.rdata = st_ff.strokes;
        `PSPC_REG_PULSES:  nxt_st.rdata = {st_ff.rej_cnt, st_ff.acc_cnt};
        default:           nxt_st.rdata = 16'h0000;
      endcase
    end

    // drive and indicators; the mode colour is dark while a stroke runs
    nxt_st.stroke = rif.stroke_on;
    nxt_st.led_g  = ready && !remote && !rif.stroke_on;
    nxt_st.led_y  = ready && remote && !rif.stroke_on;
    nxt_st.led_r  = low_on;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      st_ff <= '{sync1: '0, sync2: '0, init_cnt: 2'h0, mode: PSPC_LOCAL, btn_a: 1'b1, btn_b: 1'b1,
                 pq: PSPC_PQ_OPEN, hi_ms: 8'h00, gap_ms: 8'hFF, gap_ok: 1'b0, credit: 1'b0,
                 analog: 1'b0, knob: `PSPC_KNOB_RST, ma_in: 16'h0000, fast: `PSPC_FAST_RST,
                 slow: `PSPC_SLOW_RST, rdata: 16'h0000, strokes: 16'h0000, acc_cnt: 8'h00,
                 rej_cnt: 8'h00, stroke_d: 1'b0, nv_d: 1'b0, nv_wr: 1'b0, stroke: 1'b0,
                 led_g: 1'b0, led_y: 1'b0, led_r: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign REG_RDATA  = st_ff.rdata;
  assign NV_MODE_D  = st_ff.nv_d;
  assign NV_WR      = st_ff.nv_wr;
  assign STROKE     = st_ff.stroke;
  assign LED_GREEN  = st_ff.led_g;
  assign LED_YELLOW = st_ff.led_y;
  assign LED_RED    = st_ff.led_r;

endmodule

// File: verification/pspc_checker_asserts.sv
module pspc_checker #(
  parameter int MS_CYCLES = 10
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // contacts
  input wire logic MODE_BUTTON,
  input wire logic REMOTE_ON,
  input wire logic LOW_LEVEL,
  // outputs watched
  input wire logic NV_WR,
  input wire logic STROKE,
  input wire logic LED_GREEN,
  input wire logic LED_YELLOW,
  input wire logic LED_RED
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STK = 100 * MS_CYCLES;
  localparam int GAP = 250 * MS_CYCLES;
  logic [31:0] hi_ff;
  logic [31:0] gap_ff;
  logic [31:0] btn_ff;
  logic        stk_ff;

  // stroke length, start spacing and press age; the last two saturate so long idles never wrap
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      hi_ff  <= 32'h0;
      gap_ff <= 32'hFFFFFFFF;
      btn_ff <= 32'hFFFF;
      stk_ff <= 1'b0;
    end else begin
      hi_ff  <= STROKE ? hi_ff + 32'h1 : 32'h0;
      gap_ff <= (STROKE && !stk_ff) ? 32'h1 : (gap_ff < 32'hFFFFFFFF ? gap_ff + 32'h1 : gap_ff);
      btn_ff <= MODE_BUTTON ? 32'h0 : (btn_ff < 32'hFFFF ? btn_ff + 32'h1 : btn_ff);
      stk_ff <= STROKE;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  a_toggle_by_press: assert property (NV_WR |-> btn_ff < 8)
    else $error("mode store write without a button press");
  a_nv_write_single: assert property (NV_WR |=> !NV_WR)
    else $error("mode store write longer than one cycle");
  a_led_one_colour: assert property (!(LED_GREEN && LED_YELLOW))
    else $error("green and yellow lit together");
  a_led_dark_stroke: assert property ($rose(STROKE) |-> ##[0:1] !(LED_GREEN || LED_YELLOW))
    else $error("indicator lit during stroke");
  a_stroke_length: assert property ($fell(STROKE) |-> hi_ff >= STK - MS_CYCLES && hi_ff <= STK + MS_CYCLES)
    else $error("stroke length off");
  a_stroke_spacing: assert property ($rose(STROKE) |-> gap_ff >= GAP - MS_CYCLES)
    else $error("strokes closer than the rate cap");
  a_low_no_stroke: assert property (LOW_LEVEL [*6] |=> !$rose(STROKE))
    else $error("stroke started while empty");
  a_low_red_lit: assert property (LOW_LEVEL [*8] |-> LED_RED)
    else $error("red indicator dark while empty");
  a_remote_gate: assert property ((!REMOTE_ON && LED_YELLOW) [*6] |=> !$rose(STROKE))
    else $error("stroke started with remote contact open");

  c_stroke: cover property ($rose(STROKE));
  c_toggle: cover property (NV_WR);
  c_low: cover property ($rose(LED_RED));
endmodule

bind pspc_top pspc_checker #(.MS_CYCLES(MS_CYCLES)) i_pspc_checker (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .MODE_BUTTON(MODE_BUTTON), .REMOTE_ON(REMOTE_ON),
  .LOW_LEVEL(LOW_LEVEL), .NV_WR(NV_WR), .STROKE(STROKE), .LED_GREEN(LED_GREEN),
  .LED_YELLOW(LED_YELLOW), .LED_RED(LED_RED)
);

// File: verification/pspc_contacts.sv
module pspc_contacts (
  // clock
  input  wire logic        clk,
  // pulse train request
  input  wire logic        go,
  input  wire logic [15:0] close_cyc,
  input  wire logic [15:0] open_cyc,
  input  wire logic [7:0]  count,
  output logic             pulse,
  output logic             busy,
  // nonvolatile mode store
  input  wire logic        nv_wr,
  input  wire logic        nv_mode_d,
  output logic             nv_mode,
  output logic             nv_valid
);
  timeunit 1ns;
  timeprecision 1ns;

  // empty store at power-up
  initial begin
    pulse    = 1'b0;
    busy     = 1'b0;
    nv_mode  = 1'b0;
    nv_valid = 1'b0;
  end

  // store keeps its value through reset, as flash would
  always @(posedge clk) begin
    if (nv_wr) begin
      nv_mode  <= nv_mode_d;
      nv_valid <= 1'b1;
    end
  end

  // closure train; short figures break the timing only when a test asks for it
  always begin
    @(posedge clk);
    if (go) begin
      busy <= 1'b1;
      for (int i = 0; i < count; i++) begin
        pulse <= 1'b1;
        repeat (close_cyc) @(posedge clk);
        pulse <= 1'b0;
        repeat (open_cyc) @(posedge clk);
      end
      busy <= 1'b0;
    end
  end
endmodule

// File: verification/tb_top.sv
`include "pspc_regs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS = 10;
  // design ports
  logic        clk;
  logic        rst;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        button;
  logic        remote_on;
  logic        pulse;
  logic        low;
  logic        nv_mode;
  logic        nv_valid;
  logic        nv_mode_d;
  logic        nv_wr;
  logic        stroke;
  logic        led_g;
  logic        led_y;
  logic        led_r;
  // partner control
  logic        go;
  logic [15:0] close_cyc;
  logic [15:0] open_cyc;
  logic [7:0]  count;
  logic        busy;
  logic [15:0] v;
  int          error_cnt;
  int          cmp_count;

  pspc_top #(.MS_CYCLES(MS)) i_pspc_top (
    .SYS_CLK(clk), .RESET(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .MODE_BUTTON(button), .REMOTE_ON(remote_on), .PULSE_IN(pulse), .LOW_LEVEL(low),
    .NV_MODE(nv_mode), .NV_VALID(nv_valid), .NV_MODE_D(nv_mode_d), .NV_WR(nv_wr), .STROKE(stroke),
    .LED_GREEN(led_g), .LED_YELLOW(led_y), .LED_RED(led_r)
  );
  pspc_contacts i_pspc_contacts (
    .clk(clk), .go(go), .close_cyc(close_cyc), .open_cyc(open_cyc), .count(count), .pulse(pulse),
    .busy(busy), .nv_wr(nv_wr), .nv_mode_d(nv_mode_d), .nv_mode(nv_mode), .nv_valid(nv_valid)
  );

  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // a gap cycle after each strobe keeps every signal to one assignment per step
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
  endtask

  task automatic rng(input logic [3:0] a, input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] d;
    rd_reg(a, d);
    chk({15'h0, (d >= lo) && (d <= hi)}, 16'h0001);
  endtask

  task automatic stat(input int b, input logic e);
    logic [15:0] d;
    rd_reg(`PSPC_REG_STATUS, d);
    chk({15'h0, d[b]}, {15'h0, e});
  endtask

  task automatic clr;
    wr_reg(`PSPC_REG_STROKES, 16'h0000);
    wr_reg(`PSPC_REG_PULSES, 16'h0000);
  endtask

  // closure train from the partner, waited for under a bound
  task automatic pulses(input logic [15:0] c, input logic [15:0] o, input logic [7:0] n);
    go        <= 1'b1;
    close_cyc <= c;
    open_cyc  <= o;
    count     <= n;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 200000 && busy; i++) @(posedge clk);
    if (busy) begin
      error_cnt++;
      test_done();
    end
  endtask

  // released sample, then held over several ms samples
  task automatic press;
    button <= 1'b1;
    cyc(4 * MS);
    button <= 1'b0;
    cyc(110 * MS);
  endtask

  // hang guard
  initial begin
    cyc(95000);
    error_cnt++;
    test_done();
  end

  initial begin
    {rst, go, wr, rd, button, remote_on, low} = 7'h01 << 6;
    {addr, wdata, close_cyc, open_cyc, count} = '0;
    error_cnt = 0;
    cmp_count = 0;
    cyc(2);
    rst <= 1'b0;
    cyc(10);
    // defaults after power-up with an empty store
    stat(`PSPC_STAT_MODE_BIT, 1'b0);
    chk({15'h0, led_g}, 16'h0001);
    rd_reg(`PSPC_REG_KNOB, v);
    chk(v, 16'h0032);
    rd_reg(`PSPC_REG_FAST, v);
    chk(v, 16'h4E20);
    rd_reg(`PSPC_REG_SLOW, v);
    chk(v, 16'h0FA0);
    rd_reg(4'h9, v);
    chk(v, 16'h0000);
    // local pacing at full knob while the remote contact stays open
    wr_reg(`PSPC_REG_KNOB, 16'h00C8);
    rd_reg(`PSPC_REG_KNOB, v);
    chk(v, 16'h0064);
    clr();
    cyc(1500 * MS);
    rng(`PSPC_REG_STROKES, 16'h5, 16'h7);
    // to remote, contact open: pulses neither counted nor stroked
    press();
    stat(`PSPC_STAT_MODE_BIT, 1'b1);
    chk({14'h0, led_y, led_g}, 16'h0002);
    chk({15'h0, nv_mode}, 16'h0001);
    clr();
    pulses(30 * MS, 300 * MS, 2);
    rng(`PSPC_REG_STROKES, 16'h0, 16'h0);
    rng(`PSPC_REG_PULSES, 16'h0, 16'h0);
    // slow train: one stroke per pulse
    remote_on <= 1'b1;
    cyc(5);
    clr();
    pulses(30 * MS, 300 * MS, 3);
    rng(`PSPC_REG_STROKES, 16'h3, 16'h3);
    rng(`PSPC_REG_PULSES, 16'h3, 16'h3);
    // too short, then too close behind
    clr();
    pulses(20 * MS, 300 * MS, 1);
    pulses(30 * MS, 10 * MS, 2);
    cyc(5);
    rng(`PSPC_REG_PULSES, 16'h0201, 16'h0201);
    // 1000 per minute train is capped
    cyc(300 * MS);
    clr();
    pulses(30 * MS, 30 * MS, 10);
    cyc(400 * MS);
    rng(`PSPC_REG_STROKES, 16'h3, 16'h4);
    rng(`PSPC_REG_PULSES, 16'hA, 16'hA);
    // empty tank wins over pulses
    low <= 1'b1;
    cyc(20);
    chk({15'h0, led_r}, 16'h0001);
    stat(`PSPC_STAT_LOW_BIT, 1'b1);
    clr();
    pulses(30 * MS, 300 * MS, 1);
    rng(`PSPC_REG_STROKES, 16'h0, 16'h0);
    low <= 1'b0;
    // second reset brings back the stored mode
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(10);
    stat(`PSPC_STAT_MODE_BIT, 1'b1);
    // analog: above fast level runs full, below slow level stops
    wr_reg(`PSPC_REG_CTRL, 16'h0001);
    wr_reg(`PSPC_REG_ANALOG, 16'h61A8);
    cyc(5);
    stat(`PSPC_STAT_RUN_BIT, 1'b1);
    clr();
    cyc(1500 * MS);
    rng(`PSPC_REG_STROKES, 16'h5, 16'h7);
    // below the slow level the gate stays open but nothing is paced
    wr_reg(`PSPC_REG_ANALOG, 16'h0F9F);
    cyc(5);
    stat(`PSPC_STAT_RUN_BIT, 1'b1);
    cyc(110 * MS);
    clr();
    cyc(300 * MS);
    rng(`PSPC_REG_STROKES, 16'h0, 16'h0);
    wr_reg(`PSPC_REG_ANALOG, 16'h0FA0);
    cyc(110 * MS);
    clr();
    cyc(300 * MS);
    rng(`PSPC_REG_STROKES, 16'h0, 16'h0);
    wr_reg(`PSPC_REG_ANALOG, 16'h4E20);
    remote_on <= 1'b0;
    cyc(5);
    stat(`PSPC_STAT_RUN_BIT, 1'b0);
    // back to local
    press();
    stat(`PSPC_STAT_MODE_BIT, 1'b0);
    chk({15'h0, led_g | stroke}, 16'h0001);
    test_done();
  end
endmodule
